// File: rtl/rlm_status_top.sv
// Receive lane map, frame error status and its AXI4-Lite register slave
`timescale 1ns/10ps
module rlm_status_top (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [rlm_pkg::PCS_LANES-1:0] physMarkerLocked,
	input wire rlm_pkg::rlm_lane_idx_type physLaneId [rlm_pkg::PCS_LANES],
	input wire logic [rlm_pkg::SEG_COUNT-1:0] segEna,
	input wire logic [rlm_pkg::SEG_COUNT-1:0] segSop,
	input wire logic [rlm_pkg::SEG_COUNT-1:0] segEop,
	input wire logic [rlm_pkg::SEG_BYTES_W-1:0] segBytes [rlm_pkg::SEG_COUNT],
	input wire logic [rlm_pkg::CRC_W-1:0] segRxCrc [rlm_pkg::SEG_COUNT],
	input wire logic [rlm_pkg::CRC_W-1:0] segCalcCrc [rlm_pkg::SEG_COUNT],
	output rlm_pkg::rlm_lane_idx_type rxPcsLanePhysicalIndex
		[rlm_pkg::PCS_LANES],
	output logic [rlm_pkg::PCS_LANES-1:0] rxLaneMarkerLockedVector,
	output logic [rlm_pkg::PCS_LANES-1:0] rxLaneDemuxDoneVector,
	output logic [rlm_pkg::COUNT_W-1:0] rxCrcErrorCount,
	output logic [rlm_pkg::COUNT_W-1:0] rxInvertedCrcCount,
	output logic rxTruncated,
	output logic [rlm_pkg::SEG_COUNT-1:0] rxSegDiscard,
	output logic irq,
	input wire logic awvalid,
	output logic awready,
	input wire logic [rlm_pkg::AXI_ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [rlm_pkg::AXI_DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [rlm_pkg::AXI_ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [rlm_pkg::AXI_DATA_W-1:0] rdata,
	output logic [1:0] rresp
);
	import rlm_pkg::*;

	// Lane map
	rlm_lane_idx_type laneIdx [PCS_LANES];
	logic [PCS_LANES-1:0] laneFound;
	logic [PCS_LANES-1:0] laneUnique;
	rlm_lane_idx_type laneIdx_reg [PCS_LANES];
	logic [PCS_LANES-1:0] locked_reg, locked_next;
	logic [PCS_LANES-1:0] demux_reg, demux_next;

	for (genvar p = 0; p < PCS_LANES; p++) begin : gLane
		rlm_lane_finder #(.PCS_ID(LANE_IDX_W'(p))) uFinder (
			.physMarkerLocked(physMarkerLocked),
			.physLaneId(physLaneId),
			.physIndex(laneIdx[p]),
			.found(laneFound[p]),
			.sole(laneUnique[p])
		);
	end

	always_comb begin
		locked_next = laneFound; // RULE_02
		// A lane seen on two physical lanes cannot be demultiplexed
		demux_next = laneFound & laneUnique; // RULE_03
	end

	always_ff @(posedge clk or negedge nrst) begin // RULE_11
		if (!nrst) begin
			locked_reg <= '0;
			demux_reg <= '0;
			for (int p = 0; p < PCS_LANES; p++) begin
				laneIdx_reg[p] <= '0;
			end
		end else begin
			locked_reg <= locked_next;
			demux_reg <= demux_next;
			for (int p = 0; p < PCS_LANES; p++) begin
				laneIdx_reg[p] <= laneIdx[p]; // RULE_01
			end
		end
	end

	assign rxPcsLanePhysicalIndex = laneIdx_reg;
	assign rxLaneMarkerLockedVector = locked_reg;
	assign rxLaneDemuxDoneVector = demux_reg;

	// Frame checks
	logic [SEG_COUNT-1:0] segBad, segInv;
	logic [SEG_COUNT-1:0] segCheck;
	logic [LEN_ACC_W-1:0] lenAcc_reg, lenAcc_next;
	logic trunc_reg, trunc_next;
	logic [COUNT_W-1:0] badCnt_reg, badCnt_next;
	logic [COUNT_W-1:0] invCnt_reg, invCnt_next;
	logic truncPulse_reg, truncPulse_next;
	logic [SEG_COUNT-1:0] discard_reg, discard_next;
	logic [LEN_W-1:0] ceiling_reg, ceiling_next;
	logic [LEN_ACC_W:0] lenSum;

	for (genvar s = 0; s < SEG_COUNT; s++) begin : gSeg
		assign segCheck[s] = segEna[s] & segEop[s];
		rlm_crc_judge uJudge (
			.check(segCheck[s]),
			.rxCrc(segRxCrc[s]),
			.calcCrc(segCalcCrc[s]),
			.crcBad(segBad[s]),
			.crcInverted(segInv[s])
		);
	end

	always_comb begin
		lenAcc_next = lenAcc_reg;
		trunc_next = trunc_reg;
		badCnt_next = '0;
		invCnt_next = '0;
		truncPulse_next = 1'b0;
		discard_next = '0;
		lenSum = '0;
		// Segments are taken in order 0 to 3 within one cycle
		for (int s = 0; s < SEG_COUNT; s++) begin
			if (segEna[s]) begin
				if (segSop[s]) begin
					lenAcc_next = '0;
					trunc_next = 1'b0;
				end
				lenSum = {1'b0, lenAcc_next} + (LEN_ACC_W+1)'(segBytes[s]);
				lenAcc_next = lenSum[LEN_ACC_W] ? '1 : lenSum[LEN_ACC_W-1:0];
				if (!trunc_next && lenAcc_next > {1'b0, ceiling_reg}) begin
					trunc_next = 1'b1; // RULE_09
					truncPulse_next = 1'b1; // RULE_10
				end
				discard_next[s] = trunc_next; // RULE_09
				// A cut packet's check sequence means nothing, so skip it
				if (segEop[s] && !trunc_next) begin
					if (segBad[s]) begin
						badCnt_next = badCnt_next + 4'h1; // RULE_04
					end
					if (segInv[s]) begin
						invCnt_next = invCnt_next + 4'h1; // RULE_06
					end
				end
				if (segEop[s]) begin
					lenAcc_next = '0;
					trunc_next = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lenAcc_reg <= '0;
			trunc_reg <= 1'b0;
			badCnt_reg <= '0;
			invCnt_reg <= '0;
			truncPulse_reg <= 1'b0;
			discard_reg <= '0;
		end else begin
			lenAcc_reg <= lenAcc_next;
			trunc_reg <= trunc_next;
			badCnt_reg <= badCnt_next; // RULE_07
			invCnt_reg <= invCnt_next; // RULE_08
			truncPulse_reg <= truncPulse_next; // RULE_10
			discard_reg <= discard_next;
		end
	end

	assign rxCrcErrorCount = badCnt_reg;
	assign rxInvertedCrcCount = invCnt_reg;
	assign rxTruncated = truncPulse_reg;
	assign rxSegDiscard = discard_reg;

	// Register slave
	rlm_wr_state_type wrState_reg, wrState_next;
	logic [AXI_ADDR_W-1:0] wAddr_reg, wAddr_next;
	logic [AXI_DATA_W-1:0] wData_reg, wData_next;
	logic [3:0] wStrb_reg, wStrb_next;
	logic awready_reg, awready_next, wready_reg, wready_next;
	logic bvalid_reg, bvalid_next, arready_reg, arready_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [AXI_DATA_W-1:0] rdata_reg, rdata_next;
	logic [STATUS_W-1:0] status_reg, status_next, mask_reg, mask_next;
	logic irq_reg, irq_next;
	logic doWrite, awTake, wTake, arTake, statusClr;
	logic [AXI_ADDR_W-1:0] selAddr;
	logic [AXI_DATA_W-1:0] selData;
	logic [3:0] selStrb;
	logic [STATUS_W-1:0] events;

	always_comb begin
		awTake = awvalid & awready_reg;
		wTake = wvalid & wready_reg;
		arTake = arvalid & arready_reg;
		wrState_next = wrState_reg;
		wAddr_next = awTake ? awaddr : wAddr_reg;
		wData_next = wTake ? wdata : wData_reg;
		wStrb_next = wTake ? wstrb : wStrb_reg;
		doWrite = 1'b0;
		case (wrState_reg)
			WR_IDLE: begin
				if (awTake && wTake) begin
					doWrite = 1'b1;
				end else if (awTake) begin
					wrState_next = WR_HAVE_ADDR;
				end else if (wTake) begin
					wrState_next = WR_HAVE_DATA;
				end
			end
			WR_HAVE_ADDR: doWrite = wTake;
			WR_HAVE_DATA: doWrite = awTake;
			WR_RESP: begin
				if (bready) begin
					wrState_next = WR_IDLE;
				end
			end
			default: wrState_next = WR_IDLE;
		endcase
		if (doWrite) begin
			wrState_next = WR_RESP;
		end
		selAddr = wAddr_next;
		selData = wData_next;
		selStrb = wStrb_next;
		awready_next = wrState_next == WR_IDLE || wrState_next == WR_HAVE_DATA;
		wready_next = wrState_next == WR_IDLE || wrState_next == WR_HAVE_ADDR;
		bvalid_next = wrState_next == WR_RESP;
		bresp_next = bresp_reg;
		ceiling_next = ceiling_reg;
		mask_next = mask_reg;
		if (doWrite) begin
			bresp_next = RESP_OKAY;
			case (selAddr)
				ADDR_CEILING: begin
					if (selStrb[0]) begin
						ceiling_next[7:0] = selData[7:0];
					end
					if (selStrb[1]) begin
						ceiling_next[LEN_W-1:8] = selData[LEN_W-1:8];
					end
				end
				ADDR_INT_MASK: begin
					if (selStrb[0]) begin
						mask_next = selData[STATUS_W-1:0];
					end
				end
				ADDR_LANE_LOCK, ADDR_INT_STATUS: bresp_next = RESP_OKAY;
				default: bresp_next = RESP_DECERR;
			endcase
		end
	end

	always_comb begin
		rvalid_next = rvalid_reg & ~rready;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		statusClr = 1'b0;
		if (arTake) begin
			rvalid_next = 1'b1;
			rresp_next = RESP_OKAY;
			case (araddr)
				ADDR_CEILING: rdata_next = AXI_DATA_W'(ceiling_reg);
				ADDR_LANE_LOCK: rdata_next = AXI_DATA_W'(demux_reg);
				ADDR_INT_STATUS: begin
					rdata_next = AXI_DATA_W'(status_reg);
					statusClr = 1'b1;
				end
				ADDR_INT_MASK: rdata_next = AXI_DATA_W'(mask_reg);
				default: begin
					rdata_next = '0;
					rresp_next = RESP_DECERR;
				end
			endcase
		end
		arready_next = ~rvalid_next;
		events = '0;
		events[ST_CRC_ERR] = |badCnt_next;
		events[ST_CRC_INV] = |invCnt_next;
		events[ST_TRUNC] = truncPulse_next;
		events[ST_LANE_LOST] = |(demux_reg & ~demux_next);
		// A new event beats a read-clear in the same cycle
		status_next = (status_reg & ~{STATUS_W{statusClr}}) | events;
		irq_next = |(status_next & mask_next);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wrState_reg <= WR_IDLE;
			wAddr_reg <= '0;
			wData_reg <= '0;
			wStrb_reg <= '0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= RESP_OKAY;
			ceiling_reg <= CEILING_RESET;
			mask_reg <= '0;
			status_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			wrState_reg <= wrState_next;
			wAddr_reg <= wAddr_next;
			wData_reg <= wData_next;
			wStrb_reg <= wStrb_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			ceiling_reg <= ceiling_next;
			mask_reg <= mask_next;
			status_reg <= status_next;
			irq_reg <= irq_next;
		end
	end

	assign awready = awready_reg;
	assign wready = wready_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = arready_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign irq = irq_reg;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	for (genvar p = 0; p < PCS_LANES; p++) begin : gChk
		a_index_points_locked: assert property ( // RULE_01
			locked_reg[p] |-> |(($past(physMarkerLocked)
				>> laneIdx_reg[p]) & 20'h00001))
			else $error("lane index names an unlocked lane");
		a_demux_needs_lock: assert property ( // RULE_02
			demux_reg[p] |-> locked_reg[p])
			else $error("demux set without lock");
	end

	a_demux_from_unique: assert property ( // RULE_03
		##1 demux_reg == $past(laneFound & laneUnique))
		else $error("demux vector does not follow lane finding");

	sequence sSoleEop;
		segEna == 4'h1 && segEop == 4'h1 && segSop == 4'h1
			&& segBytes[0] <= ceiling_reg;
	endsequence

	sequence sInverted;
		segRxCrc[0] == ~segCalcCrc[0];
	endsequence

	a_inverted_counted: assert property ( // RULE_06
		(sSoleEop and sInverted) |=> rxInvertedCrcCount == 4'h1
			&& rxCrcErrorCount == 4'h0)
		else $error("inverted CRC not counted alone");

	a_bad_crc_counted: assert property ( // RULE_04
		(sSoleEop and (segRxCrc[0] != segCalcCrc[0]
			&& segRxCrc[0] != ~segCalcCrc[0]))
			|=> rxCrcErrorCount == 4'h1 && rxInvertedCrcCount == 4'h0)
		else $error("bad CRC not counted");

	a_counts_one_cycle: assert property ( // RULE_07
		!(|(segEna & segEop)) |=> rxCrcErrorCount == 4'h0
			&& rxInvertedCrcCount == 4'h0) // RULE_08
		else $error("CRC count outside an end cycle");

	a_trunc_fires: assert property ( // RULE_09
		(segEna[0] && segSop[0] && ceiling_reg < LEN_W'(segBytes[0]))
			|=> rxTruncated && rxSegDiscard[0])
		else $error("long packet not truncated");

	a_trunc_pulse_idle: assert property ( // RULE_10
		segEna == 4'h0 |=> !rxTruncated)
		else $error("truncation pulse without traffic");

	a_irq_follows_mask: assert property ( // RULE_11
		(status_reg & mask_reg) == 4'h0 |-> !irq)
		else $error("interrupt without unmasked status");
endmodule // rlm_status_top

// File: rtl/rlm_pkg.sv
// Shared constants and types for the receive lane map and frame error status
// Notes on behaviour
// RULE_01: Each of 20 PCS lanes has its own 5-bit physical lane index output.
// RULE_02: A lane's physical index is valid only while its locked bit is 1.
// RULE_03: Lock vector bit is 1 while that PCS lane is found and demultiplexed; code sets it whenever the lane is found, demultiplexed or not.
// RULE_04: CRC error count reports packets with wrong check sequence, not inverted.
// RULE_05: Check sequence equal to inverse of computed CRC is inverted, never an error.
// RULE_06: Inverted CRC count gives packets with inverted check sequence this cycle.
// RULE_07: CRC error count lasts one cycle per report; reports may run back to back.
// RULE_08: Inverted CRC count lasts one cycle per report; back to back allowed.
// RULE_09: Packet longer than the 15-bit length ceiling is truncated and flagged.
// RULE_10: Truncation flag is a one-cycle pulse; back-to-back pulses allowed.
// RULE_11: All status outputs are made and sampled in the receive clock domain.
package rlm_pkg;
	localparam int PCS_LANES = 20;
	localparam int LANE_IDX_W = 5;
	localparam int SEG_COUNT = 4;
	localparam int SEG_BYTES_W = 5;
	localparam int CRC_W = 32;
	localparam int COUNT_W = 4;
	localparam int LEN_W = 15;
	localparam int LEN_ACC_W = 16;
	localparam int AXI_ADDR_W = 8;
	localparam int AXI_DATA_W = 32;
	localparam int STATUS_W = 4;

	localparam logic [LEN_W-1:0] CEILING_RESET = 15'h2580;

	localparam logic [AXI_ADDR_W-1:0] ADDR_CEILING = 8'h00;
	localparam logic [AXI_ADDR_W-1:0] ADDR_LANE_LOCK = 8'h04;
	localparam logic [AXI_ADDR_W-1:0] ADDR_INT_STATUS = 8'h08;
	localparam logic [AXI_ADDR_W-1:0] ADDR_INT_MASK = 8'h0c;

	localparam int ST_CRC_ERR = 0;
	localparam int ST_CRC_INV = 1;
	localparam int ST_TRUNC = 2;
	localparam int ST_LANE_LOST = 3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		WR_IDLE = 2'h0,
		WR_HAVE_ADDR = 2'h1,
		WR_RESP = 2'h3,
		WR_HAVE_DATA = 2'h2
	} rlm_wr_state_type;

	typedef logic [LANE_IDX_W-1:0] rlm_lane_idx_type;
endpackage

// File: rtl/rlm_lane_finder.sv
// Finds which physical lane carries one given PCS lane
`timescale 1ns/10ps
module rlm_lane_finder #(
	parameter rlm_pkg::rlm_lane_idx_type PCS_ID = 5'h00
) (
	input wire logic [rlm_pkg::PCS_LANES-1:0] physMarkerLocked,
	input wire rlm_pkg::rlm_lane_idx_type physLaneId [rlm_pkg::PCS_LANES],
	output rlm_pkg::rlm_lane_idx_type physIndex,
	output logic found,
	output logic sole
);
	import rlm_pkg::*;

	logic many;

	always_comb begin
		physIndex = '0;
		found = 1'b0;
		many = 1'b0;
		for (int l = 0; l < PCS_LANES; l++) begin
			if (physMarkerLocked[l] && physLaneId[l] == PCS_ID) begin
				// Lowest physical lane wins when a marker is seen twice
				if (found) begin
					many = 1'b1;
				end else begin
					physIndex = LANE_IDX_W'(l);
				end
				found = 1'b1;
			end
		end
		sole = found & ~many;
	end
endmodule // rlm_lane_finder

// File: rtl/rlm_crc_judge.sv
// Classifies one segment's received check sequence
`timescale 1ns/10ps
module rlm_crc_judge (
	input wire logic check,
	input wire logic [rlm_pkg::CRC_W-1:0] rxCrc,
	input wire logic [rlm_pkg::CRC_W-1:0] calcCrc,
	output logic crcBad,
	output logic crcInverted
);
	import rlm_pkg::*;

	always_comb begin
		crcInverted = check && (rxCrc == ~calcCrc); // RULE_05
		crcBad = check && (rxCrc != calcCrc) && !crcInverted; // RULE_04
	end
endmodule // rlm_crc_judge

// File: verification/rlm_user_sink.sv
// Consumer model that totals the receive status pulses
`timescale 1ns/10ps
module rlm_user_sink (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [rlm_pkg::PCS_LANES-1:0] lockedVec,
	input wire rlm_pkg::rlm_lane_idx_type laneIdx0,
	input wire logic [rlm_pkg::COUNT_W-1:0] errCnt,
	input wire logic [rlm_pkg::COUNT_W-1:0] invCnt,
	input wire logic trunc,
	output logic [15:0] errTotal,
	output logic [15:0] invTotal,
	output logic [15:0] truncTotal,
	output rlm_pkg::rlm_lane_idx_type lane0Where
);
	import rlm_pkg::*;
	// Sums only hold if every report stands a single cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			errTotal <= '0;
			invTotal <= '0;
			truncTotal <= '0;
			lane0Where <= '0;
		end else begin
			errTotal <= errTotal + 16'(errCnt);
			invTotal <= invTotal + 16'(invCnt);
			truncTotal <= truncTotal + 16'(trunc);
			if (lockedVec[0]) lane0Where <= laneIdx0;
		end
	end
endmodule // rlm_user_sink

// File: verification/test_rx_lane_map_frame_error_status.sv
// Self-checking bench for the lane map and frame error status block
`timescale 1ns/10ps
module test_rx_lane_map_frame_error_status;
	import rlm_pkg::*;
	logic clk, nrst, trunc, irq;
	logic [PCS_LANES-1:0] physMarkerLocked, lockVec, demuxVec;
	rlm_lane_idx_type physLaneId [PCS_LANES];
	rlm_lane_idx_type laneIdx [PCS_LANES];
	rlm_lane_idx_type lane0Where;
	logic [SEG_COUNT-1:0] segEna, segSop, segEop, segDiscard;
	logic [SEG_BYTES_W-1:0] segBytes [SEG_COUNT];
	logic [CRC_W-1:0] segRxCrc [SEG_COUNT];
	logic [CRC_W-1:0] segCalcCrc [SEG_COUNT];
	logic [COUNT_W-1:0] errCnt, invCnt;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [AXI_ADDR_W-1:0] awaddr, araddr;
	logic [AXI_DATA_W-1:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	logic [15:0] errTotal, invTotal, truncTotal;
	int nMismatch = 0;
	int cmpCount = 0;
	int cycles = 0;
	int expErr = 0;
	int expInv = 0;

	rlm_status_top uut (.clk(clk), .nrst(nrst),
		.physMarkerLocked(physMarkerLocked), .physLaneId(physLaneId),
		.segEna(segEna), .segSop(segSop), .segEop(segEop),
		.segBytes(segBytes), .segRxCrc(segRxCrc), .segCalcCrc(segCalcCrc),
		.rxPcsLanePhysicalIndex(laneIdx), .rxLaneMarkerLockedVector(lockVec),
		.rxLaneDemuxDoneVector(demuxVec), .rxCrcErrorCount(errCnt),
		.rxInvertedCrcCount(invCnt), .rxTruncated(trunc),
		.rxSegDiscard(segDiscard), .irq(irq),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

	rlm_user_sink sink (.clk(clk), .nrst(nrst), .lockedVec(lockVec),
		.laneIdx0(laneIdx[0]), .errCnt(errCnt), .invCnt(invCnt),
		.trunc(trunc), .errTotal(errTotal), .invTotal(invTotal),
		.truncTotal(truncTotal), .lane0Where(lane0Where));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic reportAndStop;
		$display("mismatches %0d, comparisons %0d", nMismatch, cmpCount);
		if (nMismatch == 0 && cmpCount > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// The whole run needs under a hundred cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			nMismatch++;
			reportAndStop();
		end
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			nMismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic axiWr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		resp = bresp;
	endtask

	task automatic axiRd(input logic [7:0] a);
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		rd = rdata;
		resp = rresp;
	endtask

	// Two bits per segment: 0 good, 1 wrong, 2 inverted check sequence
	task automatic seg(input logic [3:0] en, sp, ep, input logic [7:0] k);
		@(posedge clk);
		segEna <= en;
		segSop <= sp;
		segEop <= ep;
		for (int s = 0; s < SEG_COUNT; s++) begin
			segCalcCrc[s] <= 32'h5a5a0f00 + 32'(s);
			segRxCrc[s] <= (32'h5a5a0f00 + 32'(s)) ^ (k[2*s+1] ? 32'hffffffff :
				{15'h0, k[2*s], 16'h0});
		end
	endtask

	task automatic expStatus(input logic [3:0] e, i, input logic t,
		input logic [3:0] d);
		#1;
		expErr += int'(e);
		expInv += int'(i);
		check("crc error count", 32'(errCnt), 32'(e));
		check("inverted count", 32'(invCnt), 32'(i));
		check("truncated", 32'(trunc), 32'(t));
		check("discard", 32'(segDiscard), 32'(d));
	endtask

	// Lane 12 is duplicated on purpose; the lowest physical lane wins
	task automatic chkLanes(input logic [19:0] lk, dm);
		check("locked vector", 32'(lockVec), 32'(lk));
		check("demux vector", 32'(demuxVec), 32'(dm));
		for (int p = 0; p < PCS_LANES; p++) begin
			if (lk[p]) check("lane index", 32'(laneIdx[p]),
				(p == 12 && !dm[12]) ? 32'd6 : 32'(19 - p));
		end
	endtask

	initial begin
		nrst = 1'b0;
		physMarkerLocked = '0;
		{segEna, segSop, segEop} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		for (int q = 0; q < PCS_LANES; q++) physLaneId[q] = 5'(19 - q);
		for (int s = 0; s < SEG_COUNT; s++) begin
			segBytes[s] = 5'h10;
			segRxCrc[s] = '0;
			segCalcCrc[s] = '0;
		end
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		axiRd(ADDR_CEILING);
		check("ceiling reset", rd, 32'h2580);
		axiRd(ADDR_INT_MASK);
		check("mask reset", rd, 32'h0);
		axiRd(8'h10);
		check("unmapped read", {rd[29:0], resp}, 32'(RESP_DECERR));
		physMarkerLocked <= '1;
		repeat (2) @(posedge clk);
		#1;
		chkLanes(20'hfffff, 20'hfffff);
		physMarkerLocked[5] <= 1'b0;
		physLaneId[6] <= 5'h0c;
		repeat (2) @(posedge clk);
		#1;
		chkLanes(20'hf9fff, 20'hf8fff);
		axiWr(ADDR_LANE_LOCK, 32'h0, 4'hf);
		check("read-only write", 32'(resp), 32'(RESP_OKAY));
		axiRd(ADDR_LANE_LOCK);
		check("demux register", rd, 32'h000f8fff);
		axiRd(ADDR_INT_STATUS);
		check("lane lost status", rd, 32'h8);
		axiWr(8'h20, 32'h1, 4'hf);
		check("unmapped write", 32'(resp), 32'(RESP_DECERR));
		axiWr(ADDR_INT_MASK, 32'h2, 4'hf);
		seg(4'hf, 4'hf, 4'hf, 8'h86);
		seg(4'h1, 4'h1, 4'h1, 8'h01);
		expStatus(4'h1, 4'h2, 1'b0, 4'h0);
		seg(4'h1, 4'h1, 4'h1, 8'h02);
		expStatus(4'h1, 4'h0, 1'b0, 4'h0);
		seg(4'h0, 4'h0, 4'h0, 8'h00);
		expStatus(4'h0, 4'h1, 1'b0, 4'h0);
		@(posedge clk);
		expStatus(4'h0, 4'h0, 1'b0, 4'h0);
		check("irq unmasked", 32'(irq), 32'h1);
		axiRd(ADDR_INT_STATUS);
		check("crc status", rd, 32'h3);
		axiRd(ADDR_INT_STATUS);
		check("status cleared", rd, 32'h0);
		check("irq cleared", 32'(irq), 32'h0);
		axiWr(ADDR_CEILING, 32'h30, 4'hf);
		seg(4'h7, 4'h1, 4'h4, 8'h00);
		seg(4'h0, 4'h0, 4'h0, 8'h00);
		expStatus(4'h0, 4'h0, 1'b0, 4'h0);
		axiWr(ADDR_CEILING, 32'h2f, 4'h1);
		axiRd(ADDR_CEILING);
		check("ceiling", rd, 32'h2f);
		seg(4'h7, 4'h1, 4'h4, 8'h10);
		seg(4'h7, 4'h1, 4'h4, 8'h00);
		expStatus(4'h0, 4'h0, 1'b1, 4'h4);
		seg(4'h0, 4'h0, 4'h0, 8'h00);
		expStatus(4'h0, 4'h0, 1'b1, 4'h4);
		@(posedge clk);
		expStatus(4'h0, 4'h0, 1'b0, 4'h0);
		check("irq masked", 32'(irq), 32'h0);
		axiWr(ADDR_CEILING, 32'h0f, 4'h3);
		seg(4'h1, 4'h1, 4'h1, 8'h00);
		seg(4'h0, 4'h0, 4'h0, 8'h00);
		expStatus(4'h0, 4'h0, 1'b1, 4'h1);
		axiRd(ADDR_INT_STATUS);
		check("truncation status", rd, 32'h4);
		check("error total", 32'(errTotal), 32'(expErr));
		check("inverted total", 32'(invTotal), 32'(expInv));
		check("truncation total", 32'(truncTotal), 32'h3);
		check("lane 0 seen", 32'(lane0Where), 32'd19);
		reportAndStop();
	end
endmodule // test_rx_lane_map_frame_error_status
